// [src/flpc_ctrl.sv]
// Function
// - user array is 256 pages of 128 bytes, split from flat address
// - separate 128-byte extra row, programmed and read on its own
// - security byte: upper nibble software writable, lower nibble read only
// - 128-byte page buffer is the only write path into flash spaces
// - after reset user array is code-read only, data writes leave it alone
// - latch map on: data writes 0000h-7fffh go to buffer, bits 14..7 page
// - latch map beats external ram select for data writes
// - space select 00 user, 01 extra row, 10 security byte, 11 reserved
// - launch only on key 5 then key a; 5 alone does nothing
// - launch target follows space select; 11 does nothing
// - busy blocks fetches, holds cpu idle, releases idle at completion
// - busy flag high for whole operation, cleared when done
// - boot enable maps 3-kbyte boot array over f400h-ffffh
// - 1 to 128 bytes; erase then program only loaded bytes
// - user target page is page of latest buffer write
// - control fields: key 7-4, latch map 3, select 2-1, busy 0
// - busy bit set and cleared only by hardware
// - control register resets to all zero
`include "flpc_defs.svh"

module flpc_ctrl
  import flpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic boot_space_enable,
  input wire logic external_ram_select,
  input wire logic data_wr,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] data_wdata,
  output logic xram_wr,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata,
  output logic code_ready,
  output logic program_busy_flag,
  output logic cpu_idle_req
);
  flpc_latch_if lat ();

  logic latch_map_select_q;
  logic [1:0] space_select_q;
  logic armed_q;
  logic [7:0] page_q;
  flpc_state_type state_q;
  logic [6:0] idx_q;
  logic [5:0] cnt_q;
  logic [1:0] op_sel_q;
  flpc_byte_type user_mem_q [`FLPC_USER_BYTES];
  flpc_byte_type extra_row_mem_q [`FLPC_PAGE_BYTES];
  flpc_byte_type boot_mem_q [`FLPC_BOOT_BYTES];
  logic [3:0] secu_hi_q;
  logic [3:0] secu_lo_q;
  logic [7:0] code_rdata_q;
  logic [3:0] key;
  logic latch_hit;
  logic launch;
  logic [14:0] prog_addr;

  // ===========================================================
  // control register
  // ===========================================================
  assign key = ctrl_wdata[`FLPC_KEY_MSB:`FLPC_KEY_LSB];
  assign launch = ctrl_wr && armed_q && key == `FLPC_KEY_GO && state_q == FLPC_IDLE;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      latch_map_select_q <= 1'b0;
      space_select_q <= 2'h0;
    end else if (ctrl_wr) begin
      latch_map_select_q <= ctrl_wdata[`FLPC_MAP_BIT];
      space_select_q <= ctrl_wdata[`FLPC_SEL_MSB:`FLPC_SEL_LSB];
    end
  end

  // key detector: any control write other than 5 relocks
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if (ctrl_wr) begin
      armed_q <= (key == `FLPC_KEY_ARM);
    end
  end

  // key nibble reads back zero; busy is hardware only
  assign ctrl_rdata = {4'h0, latch_map_select_q, space_select_q, program_busy_flag};

  // ===========================================================
  // data write decode
  // ===========================================================
  assign latch_hit = data_wr && latch_map_select_q && (data_addr <= `FLPC_LATCH_TOP || space_select_q != 2'h0);
  // latch map wins over external ram, flash never written directly
  assign xram_wr = data_wr && !latch_map_select_q && external_ram_select;
  assign lat.wr_en = latch_hit && state_q == FLPC_IDLE;
  assign lat.wr_idx = data_addr[6:0];
  assign lat.wr_data = data_wdata;
  assign lat.clr_all = (state_q == FLPC_NEXT && idx_q == 7'h7f) || state_q == FLPC_SECU;
  assign lat.rd_idx = idx_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      page_q <= 8'h00;
    end else if (lat.wr_en) begin
      page_q <= data_addr[14:7];
    end
  end

  flpc_latch_buf u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .lat(lat)
  );

  // ===========================================================
  // programming sequencer
  // ===========================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= FLPC_IDLE;
      idx_q <= 7'h00;
      cnt_q <= 6'h00;
      op_sel_q <= 2'h0;
    end else begin
      case (state_q)
        FLPC_IDLE: begin
          idx_q <= 7'h00;
          cnt_q <= 6'h00;
          if (launch && space_select_q != `FLPC_SEL_RSVD) begin
            op_sel_q <= space_select_q;
            state_q <= (space_select_q == `FLPC_SEL_SECU) ? FLPC_SECU : FLPC_ERASE;
          end
        end
        FLPC_ERASE: begin
          // unloaded bytes skip straight on: page remainder untouched
          if (!lat.rd_loaded) begin
            state_q <= FLPC_NEXT;
          end else if (cnt_q == 6'(`FLPC_ERASE_CYC - 1)) begin
            cnt_q <= 6'h00;
            state_q <= FLPC_PROG;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        FLPC_PROG: begin
          if (cnt_q == 6'(`FLPC_PROG_CYC - 1)) begin
            cnt_q <= 6'h00;
            state_q <= FLPC_NEXT;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        FLPC_NEXT: begin
          idx_q <= idx_q + 7'h01;
          state_q <= (idx_q == 7'h7f) ? FLPC_IDLE : FLPC_ERASE;
        end
        FLPC_SECU: begin
          state_q <= FLPC_IDLE;
        end
        default: begin
          state_q <= FLPC_IDLE;
        end
      endcase
    end
  end

  assign program_busy_flag = state_q != FLPC_IDLE;
  assign cpu_idle_req = program_busy_flag;
  assign code_ready = !program_busy_flag;

  // ===========================================================
  // flash arrays
  // ===========================================================
  assign prog_addr = {page_q, idx_q};

  always_ff @(posedge sys_clk) begin
    if (state_q == FLPC_PROG && op_sel_q == `FLPC_SEL_USER && cnt_q == 6'h00) begin
      user_mem_q[prog_addr] <= lat.rd_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (state_q == FLPC_PROG && op_sel_q == `FLPC_SEL_EXTRA_ROW && cnt_q == 6'h00) begin
      extra_row_mem_q[idx_q] <= lat.rd_data;
    end
  end

  // boot array has no write path here; parallel programming only
  // every entry is reset so no boot read ever returns an undriven byte
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int j = 0; j < `FLPC_BOOT_BYTES; j++) begin
        boot_mem_q[j] <= 8'h00;
      end
    end
  end

  // only the upper nibble takes software data; byte 0 of the buffer feeds it
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      secu_hi_q <= 4'h0;
    end else if (state_q == FLPC_SECU && lat.any_loaded) begin
      secu_hi_q <= lat.rd_data[7:4];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      secu_lo_q <= 4'h0;
    end
  end

  // ===========================================================
  // code read mux
  // ===========================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      code_rdata_q <= 8'h00;
    end else if (code_rd && code_ready) begin
      if (boot_space_enable && code_addr >= `FLPC_BOOT_BASE) begin
        code_rdata_q <= boot_mem_q[12'(code_addr - `FLPC_BOOT_BASE)];
      end else begin
        case (space_select_q)
          `FLPC_SEL_USER: code_rdata_q <= user_mem_q[code_addr[14:0]];
          `FLPC_SEL_EXTRA_ROW: code_rdata_q <= (code_addr >= `FLPC_EXTRA_ROW_BASE) ? extra_row_mem_q[code_addr[6:0]] : 8'h00;
          `FLPC_SEL_SECU: code_rdata_q <= (code_addr == `FLPC_SECU_ADDR) ? {secu_hi_q, secu_lo_q} : 8'h00;
          default: code_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign code_rdata = code_rdata_q;
endmodule

// [src/flpc_defs.svh]
`ifndef FLPC_DEFS_SVH
`define FLPC_DEFS_SVH

// control register fields
`define FLPC_KEY_MSB 7
`define FLPC_KEY_LSB 4
`define FLPC_MAP_BIT 3
`define FLPC_SEL_MSB 2
`define FLPC_SEL_LSB 1
`define FLPC_BUSY_BIT 0
`define FLPC_CTRL_RST 8'h00

// launch key values
`define FLPC_KEY_ARM 4'h5
`define FLPC_KEY_GO 4'ha

// space select codes
`define FLPC_SEL_USER 2'h0
`define FLPC_SEL_EXTRA_ROW 2'h1
`define FLPC_SEL_SECU 2'h2
`define FLPC_SEL_RSVD 2'h3

// geometry
`define FLPC_PAGE_BYTES 128
`define FLPC_PAGES 256
`define FLPC_USER_BYTES 32768
`define FLPC_BOOT_BYTES 3072
`define FLPC_BOOT_BASE 16'hf400
`define FLPC_EXTRA_ROW_BASE 16'hff80
`define FLPC_LATCH_TOP 16'h7fff
`define FLPC_SECU_ADDR 16'h0000
`define FLPC_SECU_SW_MASK 8'hf0

// per-byte erase and program times
`define FLPC_ERASE_NS 40
`define FLPC_PROG_NS 40
`define FLPC_CLK_NS 4
`define FLPC_ERASE_CYC ((`FLPC_ERASE_NS + `FLPC_CLK_NS - 1) / `FLPC_CLK_NS)
`define FLPC_PROG_CYC ((`FLPC_PROG_NS + `FLPC_CLK_NS - 1) / `FLPC_CLK_NS)

`endif

// [src/flpc_pkg.sv]
package flpc_pkg;
  typedef enum logic [2:0] {
    FLPC_IDLE,
    FLPC_ERASE,
    FLPC_PROG,
    FLPC_NEXT,
    FLPC_SECU
  } flpc_state_type;
  typedef logic [7:0] flpc_byte_type;
endpackage

// [src/flpc_latch_if.sv]
interface flpc_latch_if;
  logic wr_en;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic clr_all;
  logic [6:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_loaded;
  logic any_loaded;
  modport owner (output wr_en, wr_idx, wr_data, clr_all, rd_idx, input rd_data, rd_loaded, any_loaded);
  modport store (input wr_en, wr_idx, wr_data, clr_all, rd_idx, output rd_data, rd_loaded, any_loaded);
endinterface

// [src/flpc_latch_buf.sv]
`include "flpc_defs.svh"

module flpc_latch_buf
  import flpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  flpc_latch_if.store lat
);
  flpc_byte_type data_q [`FLPC_PAGE_BYTES];
  logic [`FLPC_PAGE_BYTES-1:0] loaded_q;

  // ===========================================================
  // column latch storage
  // ===========================================================
  genvar i;
  generate
    for (i = 0; i < `FLPC_PAGE_BYTES; i++) begin : g_byte
      always_ff @(posedge sys_clk) begin
        if (lat.wr_en && lat.wr_idx == 7'(i)) begin
          data_q[i] <= lat.wr_data;
        end
      end
      // loaded marks decide which bytes get erased and programmed
      always_ff @(posedge sys_clk) begin
        if (!nrst || lat.clr_all) begin
          loaded_q[i] <= 1'b0;
        end else if (lat.wr_en && lat.wr_idx == 7'(i)) begin
          loaded_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  assign lat.rd_data = data_q[lat.rd_idx];
  assign lat.rd_loaded = loaded_q[lat.rd_idx];
  assign lat.any_loaded = |loaded_q;
endmodule

// [dv/flpc_ctrl_chk.sv]
module flpc_ctrl_chk
  import flpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic external_ram_select,
  input wire logic data_wr,
  input wire logic xram_wr,
  input wire logic code_ready,
  input wire logic program_busy_flag,
  input wire logic cpu_idle_req
);
  // ==========
  // launch key decode
  wire logic arm_w = ctrl_wr && ctrl_wdata[7:4] == 4'h5;
  wire logic go_w = ctrl_wr && ctrl_wdata[7:4] == 4'ha;
  // key 5 stays armed until the next control write, idle gaps allowed
  logic arm_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      arm_q <= 1'b0;
    end else if (ctrl_wr) begin
      arm_q <= ctrl_wdata[7:4] == 4'h5;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ==========
  // assertions
  idle_busy_a: assert property (cpu_idle_req == program_busy_flag)
    else $error("idle request differs from busy");
  ready_busy_a: assert property (code_ready == !program_busy_flag)
    else $error("code ready not inverse of busy");
  busy_bit_a: assert property (ctrl_rdata[0] == program_busy_flag)
    else $error("busy readback differs from flag");
  ctrl_fields_a: assert property (ctrl_wr && !program_busy_flag |=>
    ctrl_rdata[7:1] == {4'h0, $past(ctrl_wdata[3:1])}) else $error("control readback wrong");
  key_launch_a: assert property (go_w && arm_q && ctrl_rdata[2:1] != 2'h3
    && !program_busy_flag |=> program_busy_flag) else $error("valid key did not launch");
  arm_only_a: assert property (arm_w && !program_busy_flag |=> !program_busy_flag)
    else $error("key 5 alone launched");
  key_relock_a: assert property (go_w && !arm_q |=> $stable(program_busy_flag))
    else $error("key a without key 5 acted");
  rsvd_launch_a: assert property (go_w && ctrl_rdata[2:1] == 2'h3 && !program_busy_flag
    |=> !program_busy_flag) else $error("reserved select launched");
  xram_pri_a: assert property (xram_wr == (data_wr && !ctrl_rdata[3] && external_ram_select))
    else $error("external ram write decode wrong");
endmodule

bind flpc_ctrl flpc_ctrl_chk u_chk (.sys_clk, .nrst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata,
  .external_ram_select, .data_wr, .xram_wr, .code_ready, .program_busy_flag, .cpu_idle_req);

// [dv/flpc_cpu_model.sv]
module flpc_cpu_model (
  input wire logic sys_clk,
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata,
  output logic data_wr,
  output logic [15:0] data_addr,
  output logic [7:0] data_wdata,
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // no interrupt source here, so idle is never left early
  initial begin
    {ctrl_wr, ctrl_wdata, data_wr, data_addr, data_wdata, code_rd, code_addr} = '0;
  end
  // key pairs and map writes come from the caller
  task automatic cw(input logic [7:0] v);
    @(posedge sys_clk);
    #1 ctrl_wr = 1'b1;
    ctrl_wdata = v;
    @(posedge sys_clk);
    #1 ctrl_wr = 1'b0;
    ctrl_wdata = ~v;
  endtask
  // one data write per byte loaded
  task automatic dw(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1 data_wr = 1'b1;
    data_addr = a;
    data_wdata = v;
    @(posedge sys_clk);
    #1 data_wr = 1'b0;
    data_addr = ~a;
    data_wdata = ~v;
  endtask
  // released address is inverted so stale values never help
  task automatic cr(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1 code_rd = 1'b1;
    code_addr = a;
    @(posedge sys_clk);
    #1 code_rd = 1'b0;
    code_addr = ~a;
    v = code_rdata;
  endtask
endmodule

// [dv/flpc_ctrl_tb.sv]
module flpc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, nrst, boot_space_enable, external_ram_select;
  logic ctrl_wr, data_wr, code_rd, xram_wr, code_ready, program_busy_flag, cpu_idle_req;
  logic [7:0] ctrl_wdata, data_wdata, ctrl_rdata, code_rdata, rd;
  logic [15:0] data_addr, code_addr;
  logic xram_seen;
  int err_count, samples_checked;
  flpc_ctrl DUT (.sys_clk, .nrst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .boot_space_enable,
    .external_ram_select, .data_wr, .data_addr, .data_wdata, .xram_wr, .code_rd, .code_addr,
    .code_rdata, .code_ready, .program_busy_flag, .cpu_idle_req);
  flpc_cpu_model cpu (.sys_clk, .ctrl_wr, .ctrl_wdata, .data_wr, .data_addr, .data_wdata,
    .code_rd, .code_addr, .code_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // external ram strobe as seen at the edge that takes the data write
  always @(posedge sys_clk) begin
    if (data_wr) begin
      xram_seen <= xram_wr;
    end
  end
  // ==========
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic levels(input logic boot, input logic xram);
    boot_space_enable = boot;
    external_ram_select = xram;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bounded, a hang ends the run
  task automatic launch(input logic [7:0] k, input logic exp_busy);
    int n;
    cpu.cw(k);
    cpu.cw({4'ha, k[3:0]});
    check("busy", {7'h0, program_busy_flag}, {7'h0, exp_busy});
    for (n = 0; program_busy_flag !== 1'b0; n++) begin
      if (n > 5000) begin
        err_count++;
        final_report();
      end
      @(posedge sys_clk);
      #1;
    end
  endtask
  // ==========
  // scenarios
  task automatic t_user();
    cpu.cw(8'h08);
    cpu.dw(16'h0105, 8'ha5);
    cpu.dw(16'h0180, 8'h3c);
    launch(8'h50, 1'b1);
    cpu.cr(16'h0185, rd);
    check("page from last write", rd, 8'ha5);
    cpu.cw(8'h08);
    cpu.dw(16'h0185, 8'h5a);
    launch(8'h50, 1'b1);
    cpu.cr(16'h0185, rd);
    check("reprogrammed byte", rd, 8'h5a);
    cpu.cr(16'h0180, rd);
    check("unloaded byte kept", rd, 8'h3c);
  endtask
  task automatic t_guard();
    levels(1'b0, 1'b1);
    cpu.cw(8'h00);
    cpu.dw(16'h0180, 8'h11);
    check("external ram write", {7'h0, xram_seen}, 8'h01);
    cpu.cw(8'h08);
    cpu.dw(16'h0181, 8'h22);
    check("latch map beats ram", {7'h0, xram_seen}, 8'h00);
    cpu.cw(8'h50);
    launch(8'h00, 1'b0);
    launch(8'h56, 1'b0);
    cpu.cw(8'h50);
    check("arm alone", {7'h0, program_busy_flag}, 8'h00);
    levels(1'b0, 1'b0);
    cpu.cw(8'h00);
    cpu.cr(16'h0180, rd);
    check("data write kept out", rd, 8'h3c);
  endtask
  task automatic t_spaces();
    cpu.cw(8'h0a);
    cpu.dw(16'hff81, 8'h77);
    launch(8'h52, 1'b1);
    cpu.cw(8'h02);
    cpu.cr(16'hff81, rd);
    check("extra row", rd, 8'h77);
    cpu.cw(8'h0c);
    cpu.dw(16'h0000, 8'h9b);
    launch(8'h54, 1'b1);
    cpu.cw(8'h04);
    cpu.cr(16'h0000, rd);
    check("security byte", rd, 8'h90);
    levels(1'b1, 1'b0);
    cpu.cw(8'h00);
    cpu.cr(16'hf400, rd);
    check("boot array", rd, 8'h00);
    cpu.cr(16'h0185, rd);
    check("user below boot", rd, 8'h5a);
    levels(1'b0, 1'b0);
  endtask
  // reserved select reads zero, then a reset in mid-run clears the register
  task automatic t_reset();
    cpu.cw(8'h0e);
    check("control readback", ctrl_rdata, 8'h0e);
    cpu.cr(16'h0185, rd);
    check("reserved select reads zero", rd, 8'h00);
    @(posedge sys_clk);
    #1 nrst = 1'b0;
    @(posedge sys_clk);
    #1 nrst = 1'b1;
    check("control reset again", ctrl_rdata, 8'h00);
  endtask
  initial begin
    nrst = 1'b0;
    levels(1'b0, 1'b0);
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check("control reset", ctrl_rdata, 8'h00);
    t_user();
    t_guard();
    t_spaces();
    t_reset();
    final_report();
  end
endmodule
